/* File: design/rxq_pkg.sv */
// Package with event codes, entry layout, routing classes and queue sizing for the
// receive queue unit. Assumes nothing beyond a SystemVerilog compiler.
package rxq_pkg;
    localparam int QUEUE_COUNT = 8;
    localparam int QUEUE_DEPTH = 16;
    localparam int PTR_WIDTH = 4;
    localparam int ENTRY_WIDTH = 32;
    localparam int TYPE_LSB = 0;
    localparam int TYPE_WIDTH = 6;
    localparam int INFO_LSB = 6;
    localparam int INFO_WIDTH = 26;
    localparam logic [ENTRY_WIDTH-1:0] ENTRY_RESET = 32'h00000000;

    localparam logic [5:0] EV_PKT_GOOD = 6'h00;
    localparam logic [5:0] EV_PKT_HEADER = 6'h01;
    localparam logic [5:0] EV_PKT_BAD_CRC = 6'h02;
    localparam logic [5:0] EV_PKT_BAD_LEN = 6'h03;
    localparam logic [5:0] EV_PKT_TOO_LONG = 6'h04;
    localparam logic [5:0] EV_PKT_TIMEOUT = 6'h05;
    localparam logic [5:0] EV_PKT_ABORT = 6'h06;
    localparam logic [5:0] EV_PKT_CPI = 6'h07;
    localparam logic [5:0] EV_CELL = 6'h08;
    localparam logic [5:0] EV_NUD_GOOD = 6'h09;
    localparam logic [5:0] EV_NUD_BAD = 6'h0A;
    localparam logic [5:0] EV_BAD_HEC = 6'h0B;
    localparam logic [5:0] EV_OUT_RANGE = 6'h0C;
    localparam logic [5:0] EV_INDEX_ZERO = 6'h0D;
    localparam logic [5:0] EV_FIFO_PKT = 6'h0E;
    localparam logic [5:0] EV_PKT_CRC_LEN_OK = 6'h0F;
    localparam logic [5:0] EV_DROP_AAL0 = 6'h10;
    localparam logic [5:0] EV_DROP_AAL5 = 6'h11;
    localparam logic [5:0] EV_DROP_NUD = 6'h12;
    localparam logic [5:0] EV_DROP_FIFO = 6'h13;
    localparam logic [5:0] EV_FIFO_THRESH = 6'h14;
    localparam logic [5:0] EV_FIFO_FULL = 6'h15;
    localparam logic [5:0] EV_FIFO_TIMEOUT = 6'h16;
    localparam logic [5:0] EV_CNT_RX = 6'h18;
    localparam logic [5:0] EV_CNT_TX_CLP0 = 6'h1B;
    localparam logic [5:0] EV_THRESH1 = 6'h1E;
    localparam logic [5:0] EV_CONN_CLOSED = 6'h23;
    localparam logic [5:0] EV_TX_DMA_OK = 6'h24;
    localparam logic [5:0] EV_RX_DMA_OK = 6'h25;
    localparam logic [5:0] EV_TX_DMA_ERR = 6'h26;
    localparam logic [5:0] EV_RX_DMA_ERR = 6'h27;
    localparam logic [5:0] EV_TX_DMA_VIRT = 6'h28;
    localparam logic [5:0] EV_DMA_ZERO = 6'h29;
    localparam logic [5:0] EV_ABR_FIRST = 6'h2C;
    localparam logic [5:0] EV_ABR_LAST = 6'h2F;
    localparam logic [5:0] EV_USER_FIRST = 6'h30;
    localparam logic [5:0] EV_USER_LAST = 6'h37;
    localparam logic [5:0] EV_VMEM = 6'h38;
    localparam logic [5:0] EV_DMA_CANCEL = 6'h3B;
    localparam logic [5:0] EV_NO_SCATTER = 6'h3C;
    localparam logic [5:0] EV_ENTITY_CNT = 6'h3D;
    localparam logic [5:0] EV_POOL_STATUS = 6'h3E;

    // Routing class bits, one per class; an event may carry two (code 29).
    localparam int CLASS_WIDTH = 7;
    localparam int CLS_ERROR = 0;
    localparam int CLS_COUNT = 1;
    localparam int CLS_TX_COMP = 2;
    localparam int CLS_TX_DMA = 3;
    localparam int CLS_RX_DMA = 4;
    localparam int CLS_ABR = 5;
    localparam int CLS_POOL = 6;

    // Producer events, one pulse each, chosen by the reassembly engine and others.
    typedef enum logic [4:0] {
        SRC_PKT_DONE, SRC_PKT_HEADER, SRC_PKT_TOO_LONG, SRC_PKT_TIMEOUT, SRC_PKT_ABORT,
        SRC_CELL, SRC_NUD_CELL, SRC_BAD_HEC, SRC_OUT_RANGE, SRC_INDEX_ZERO,
        SRC_POOL_DROP, SRC_FIFO_DROP, SRC_FIFO_THRESH, SRC_FIFO_FULL, SRC_FIFO_TIMEOUT,
        SRC_COUNTER, SRC_ENTITY_CNT, SRC_DMA, SRC_RAW
    } source_type;

    typedef enum logic [1:0] {POOL_AAL0, POOL_AAL5, POOL_NUD} pool_kind_type;
    typedef enum logic [2:0] {
        DMA_TX_OK, DMA_RX_OK, DMA_TX_ERR, DMA_RX_ERR, DMA_TX_VIRT, DMA_ZERO
    } dma_kind_type;
endpackage

/* File: design/rxq_if.sv */
// Interface carrying one encoded entry from the encoder to the queue store.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface entry_if;
    import rxq_pkg::*;
    logic valid;
    logic [2:0] queue;
    logic [ENTRY_WIDTH-1:0] entry;
    logic [CLASS_WIDTH-1:0] route_class;
    modport source (output valid, output queue, output entry, output route_class);
    modport sink (input valid, input queue, input entry, input route_class);
endinterface

/* File: design/rxq_store.sv */
// Eight independent circular queues of 32-bit entries.
// Assumes the writer offers at most one entry a cycle on the sink modport.
`timescale 1ns/1ps
module rxq_store
    import rxq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    entry_if.sink wr,
    input wire logic [2:0] rd_queue,
    input wire logic rd_en,
    output logic [ENTRY_WIDTH-1:0] rd_entry,
    output logic [QUEUE_COUNT-1:0] full,
    output logic [QUEUE_COUNT-1:0] empty
);
    logic [ENTRY_WIDTH-1:0] mem [QUEUE_COUNT][QUEUE_DEPTH];
    logic [PTR_WIDTH:0] wptr [QUEUE_COUNT];
    logic [PTR_WIDTH:0] rptr [QUEUE_COUNT];

    genvar q;
    generate
        for (q = 0; q < QUEUE_COUNT; q++) begin : g_queue
            logic do_wr;
            logic do_rd;
            assign do_wr = wr.valid && (wr.queue == 3'(q)) && !full[q];
            assign do_rd = rd_en && (rd_queue == 3'(q)) && !empty[q];
            assign full[q] = (wptr[q][PTR_WIDTH] != rptr[q][PTR_WIDTH]) &&
                             (wptr[q][PTR_WIDTH-1:0] == rptr[q][PTR_WIDTH-1:0]);
            assign empty[q] = (wptr[q] == rptr[q]);
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    wptr[q] <= '0;
                    rptr[q] <= '0;
                end else begin
                    if (do_wr) begin
                        wptr[q] <= wptr[q] + 1'b1;
                    end
                    if (do_rd) begin
                        rptr[q] <= rptr[q] + 1'b1;
                    end
                end
            end
            // Storage has no reset so it maps onto plain RAM.
            always_ff @(posedge core_clk) begin
                if (do_wr) begin
                    mem[q][wptr[q][PTR_WIDTH-1:0]] <= wr.entry;
                end
            end
        end
    endgenerate

    assign rd_entry = mem[rd_queue][rptr[rd_queue][PTR_WIDTH-1:0]];
endmodule

/* File: design/receive_event_queue_encoder.sv */
// Receive queue unit: encodes producer events into 32-bit entries and queues them.
// Assumes producers pulse one event a cycle on core_clk; software pops with deq_en.
//
// Function
// - Eight independent receive queues for software.
// - Each entry one word: type plus information.
// - Good AAL5 packet gives code 00, pointer.
// - Good FIFO-mode AAL5 packet gives code 0e.
// - Header threshold exceeded gives code 01.
// - AAL5 CRC failure with bad length gives code 02.
// - Bad CRC with good length gives 0f.
// - Length field mismatch with good CRC gives code 03.
// - Over maximum length gives code 04.
// - Reassembly timeout gives code 05.
// - Forward abort gives code 06.
// - Nonzero CPI field gives code 07.
// - Errors point to packet or channel descriptor.
// - Non-FIFO AAL0 cell gives code 08.
// - Non-user cell: 09 good, 0a bad CRC-10.
// - Bad header check gives code 0b.
// - Out of range 0c, index zero 0d.
// - Pool drops 10-12, FIFO-full drop 13.
// - FIFO threshold 14, full 15, timeout 16.
// - Counter overflows 18-1b, entity counter 3d.
// - DMA outcomes 24-29 with descriptor address.
// - Each code has at most one routing class, except 29 with two; user 30-37 none.
`timescale 1ns/1ps
module receive_event_queue_encoder
    import rxq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ev_valid,
    input source_type ev_source,
    input wire logic [2:0] ev_queue,
    input wire logic [INFO_WIDTH-1:0] ev_buffer_ptr,
    input wire logic [INFO_WIDTH-1:0] ev_descriptor_ptr,
    input wire logic ev_fifo_mode,
    input wire logic ev_crc_bad,
    input wire logic ev_length_bad,
    input wire logic ev_cpi_nonzero,
    input wire logic ev_keep_bad_frames,
    input wire logic ev_crc10_check,
    input pool_kind_type ev_pool_kind,
    input wire logic [1:0] ev_counter_sel,
    input dma_kind_type ev_dma_kind,
    input wire logic [5:0] ev_raw_code,
    input wire logic [2:0] deq_queue,
    input wire logic deq_en,
    output logic ev_ready,
    output logic [ENTRY_WIDTH-1:0] deq_entry,
    output logic deq_valid,
    output logic [QUEUE_COUNT-1:0] queue_nonempty,
    output logic [QUEUE_COUNT-1:0] queue_full,
    output logic [CLASS_WIDTH-1:0] last_class,
    output logic [QUEUE_COUNT-1:0] overflow
);
    typedef enum logic [1:0] {
        DEQ_IDLE = 2'b01,
        DEQ_SHOW = 2'b10
    } deq_state_type;

    entry_if enc();
    logic [5:0] next_code;
    logic [INFO_WIDTH-1:0] next_info;
    logic [ENTRY_WIDTH-1:0] store_entry;
    logic [QUEUE_COUNT-1:0] store_full;
    logic [QUEUE_COUNT-1:0] store_empty;
    logic store_rd;
    deq_state_type deq_state;

    // Routing class lookup, driven on the entry interface (unused by the store) and used for the class status output.
    function automatic logic [CLASS_WIDTH-1:0] class_of(input logic [5:0] code);
        logic [CLASS_WIDTH-1:0] c;
        c = '0;
        if ((code >= EV_PKT_BAD_CRC && code <= EV_PKT_CPI) || code == EV_PKT_CRC_LEN_OK ||
            (code >= EV_NUD_BAD && code <= EV_INDEX_ZERO) ||
            (code >= EV_DROP_AAL0 && code <= EV_DROP_FIFO) || code == EV_FIFO_TIMEOUT ||
            (code >= EV_VMEM && code <= EV_NO_SCATTER && code != EV_DMA_CANCEL)) begin
            c[CLS_ERROR] = 1'b1;
        end
        if ((code >= EV_CNT_RX && code <= EV_CNT_TX_CLP0) || code == EV_ENTITY_CNT) begin
            c[CLS_COUNT] = 1'b1;
        end
        if (code >= EV_THRESH1 && code <= EV_CONN_CLOSED && code != 6'h1C && code != 6'h1D) begin
            c[CLS_TX_COMP] = 1'b1;
        end
        if (code == EV_TX_DMA_OK || code == EV_TX_DMA_ERR || code == EV_TX_DMA_VIRT ||
            code == EV_DMA_ZERO) begin
            c[CLS_TX_DMA] = 1'b1;
        end
        if (code == EV_RX_DMA_OK || code == EV_RX_DMA_ERR || code == EV_DMA_ZERO ||
            code == EV_DMA_CANCEL) begin
            c[CLS_RX_DMA] = 1'b1;
        end
        if (code >= EV_ABR_FIRST && code <= EV_ABR_LAST) begin
            c[CLS_ABR] = 1'b1;
        end
        if (code == EV_POOL_STATUS) begin
            c[CLS_POOL] = 1'b1;
        end
        return c;
    endfunction

    // Error information: packet when bad frames are kept, else channel descriptor.
    function automatic logic [INFO_WIDTH-1:0] err_info(input logic keep,
            input logic [INFO_WIDTH-1:0] buf_ptr, input logic [INFO_WIDTH-1:0] desc_ptr);
        return keep ? buf_ptr : desc_ptr;
    endfunction

    // Encoder. Packet-done checks are ordered: CPI, then CRC, then length, then good.
    always_comb begin
        next_code = EV_PKT_GOOD;
        next_info = ev_buffer_ptr;
        case (ev_source)
            SRC_PKT_DONE: begin
                if (ev_cpi_nonzero) begin
                    next_code = EV_PKT_CPI;
                    next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
                end else if (ev_crc_bad && !ev_length_bad) begin
                    next_code = EV_PKT_CRC_LEN_OK;
                    next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
                end else if (ev_crc_bad) begin
                    next_code = EV_PKT_BAD_CRC;
                    next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
                end else if (ev_length_bad) begin
                    next_code = EV_PKT_BAD_LEN;
                    next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
                end else if (ev_fifo_mode) begin
                    next_code = EV_FIFO_PKT;
                end else begin
                    next_code = EV_PKT_GOOD;
                end
            end
            SRC_PKT_HEADER: begin
                next_code = EV_PKT_HEADER;
            end
            SRC_PKT_TOO_LONG: begin
                next_code = EV_PKT_TOO_LONG;
                next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
            end
            SRC_PKT_TIMEOUT: begin
                next_code = EV_PKT_TIMEOUT;
                next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
            end
            SRC_PKT_ABORT: begin
                next_code = EV_PKT_ABORT;
                next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
            end
            SRC_CELL: begin
                next_code = EV_CELL;
            end
            SRC_NUD_CELL: begin
                if (ev_crc10_check && ev_crc_bad) begin
                    next_code = EV_NUD_BAD;
                    next_info = err_info(ev_keep_bad_frames, ev_buffer_ptr, ev_descriptor_ptr);
                end else begin
                    next_code = EV_NUD_GOOD;
                end
            end
            SRC_BAD_HEC: begin
                next_code = EV_BAD_HEC;
            end
            SRC_OUT_RANGE: begin
                next_code = EV_OUT_RANGE;
            end
            SRC_INDEX_ZERO: begin
                next_code = EV_INDEX_ZERO;
            end
            SRC_POOL_DROP: begin
                next_code = EV_DROP_AAL0 + 6'(ev_pool_kind);
                next_info = ev_descriptor_ptr;
            end
            SRC_FIFO_DROP: begin
                next_code = EV_DROP_FIFO;
                next_info = ev_descriptor_ptr;
            end
            SRC_FIFO_THRESH: begin
                next_code = EV_FIFO_THRESH;
                next_info = ev_descriptor_ptr;
            end
            SRC_FIFO_FULL: begin
                next_code = EV_FIFO_FULL;
                next_info = ev_descriptor_ptr;
            end
            SRC_FIFO_TIMEOUT: begin
                next_code = EV_FIFO_TIMEOUT;
                next_info = ev_descriptor_ptr;
            end
            SRC_COUNTER: begin
                next_code = EV_CNT_RX + 6'(ev_counter_sel);
                next_info = ev_descriptor_ptr;
            end
            SRC_ENTITY_CNT: begin
                next_code = EV_ENTITY_CNT;
            end
            SRC_DMA: begin
                next_code = EV_TX_DMA_OK + 6'(ev_dma_kind);
                next_info = ev_descriptor_ptr;
            end
            default: begin
                // User events and other codes pass through with raw information.
                next_code = ev_raw_code;
            end
        endcase
    end

    // The type code takes the low six bits so software can mask it without shifts.
    assign enc.entry = {next_info, next_code};
    assign enc.valid = ev_valid;
    assign enc.queue = ev_queue;
    assign enc.route_class = class_of(next_code);

    rxq_store u_store (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr(enc),
        .rd_queue(deq_queue),
        .rd_en(store_rd),
        .rd_entry(store_entry),
        .full(store_full),
        .empty(store_empty)
    );

    // Pop request takes the head in one cycle and shows it registered the next.
    assign store_rd = deq_en && (deq_state == DEQ_IDLE) && !store_empty[deq_queue];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            deq_state <= DEQ_IDLE;
        end else begin
            case (deq_state)
                DEQ_IDLE: begin
                    if (store_rd) begin
                        deq_state <= DEQ_SHOW;
                    end
                end
                DEQ_SHOW: begin
                    deq_state <= DEQ_IDLE;
                end
                default: begin
                    deq_state <= DEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            deq_entry <= ENTRY_RESET;
            deq_valid <= 1'b0;
        end else begin
            deq_valid <= store_rd;
            if (store_rd) begin
                deq_entry <= store_entry;
            end
        end
    end

    // Status flags are registered; ev_ready follows one cycle behind the fill level,
    // so producers should treat it as a warning and the overflow bit as the loss record.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            queue_nonempty <= '0;
            queue_full <= '0;
            ev_ready <= 1'b1;
            last_class <= '0;
            overflow <= '0;
        end else begin
            queue_nonempty <= ~store_empty;
            queue_full <= store_full;
            ev_ready <= ~|store_full;
            if (ev_valid) begin
                last_class <= enc.route_class;
            end
            // Sticky lost-entry record; only reset clears it.
            if (ev_valid && store_full[ev_queue]) begin
                overflow[ev_queue] <= 1'b1;
            end
        end
    end

    property p_good_packet;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_source == SRC_PKT_DONE && !ev_cpi_nonzero && !ev_crc_bad &&
         !ev_length_bad && !ev_fifo_mode) |-> enc.entry[5:0] == EV_PKT_GOOD;
    endproperty
    a_good_packet: assert property (p_good_packet) else $error("good packet code wrong");

    property p_crc_len_ok;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_source == SRC_PKT_DONE && !ev_cpi_nonzero && ev_crc_bad &&
         !ev_length_bad) |-> enc.entry[5:0] == EV_PKT_CRC_LEN_OK;
    endproperty
    a_crc_len_ok: assert property (p_crc_len_ok) else $error("crc good-length code wrong");

    property p_error_info;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && enc.route_class[CLS_ERROR] && ev_source == SRC_PKT_TIMEOUT) |->
        enc.entry[31:6] == (ev_keep_bad_frames ? ev_buffer_ptr : ev_descriptor_ptr);
    endproperty
    a_error_info: assert property (p_error_info) else $error("error info source wrong");

    property p_pool_drop;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_source == SRC_POOL_DROP) |->
        enc.entry[31:6] == ev_descriptor_ptr && enc.route_class[CLS_ERROR];
    endproperty
    a_pool_drop: assert property (p_pool_drop) else $error("pool drop entry wrong");

    property p_dma_zero;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_source == SRC_DMA && ev_dma_kind == DMA_ZERO) |->
        enc.entry[5:0] == EV_DMA_ZERO && enc.route_class[CLS_TX_DMA] &&
        enc.route_class[CLS_RX_DMA];
    endproperty
    a_dma_zero: assert property (p_dma_zero) else $error("zero address event wrong");

    property p_counter_class;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_source == SRC_COUNTER) |-> ##1 last_class == 7'h02;
    endproperty
    a_counter_class: assert property (p_counter_class) else $error("count class lost");

    property p_fifo_order;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_queue == 3'h0 && !store_full[0] && store_empty[0] && !deq_en) ##1
        (deq_en && deq_queue == 3'h0) |-> ##1 deq_valid && deq_entry == $past(enc.entry, 2);
    endproperty
    a_fifo_order: assert property (p_fifo_order) else $error("dequeued entry mismatch");

    property p_nud_bad;
        @(posedge core_clk) disable iff (!rstn)
        (ev_valid && ev_source == SRC_NUD_CELL) |->
        enc.entry[5:0] == ((ev_crc10_check && ev_crc_bad) ? EV_NUD_BAD : EV_NUD_GOOD);
    endproperty
    a_nud_bad: assert property (p_nud_bad) else $error("non-user cell code wrong");

    c_dequeue: cover property (@(posedge core_clk) disable iff (!rstn) deq_valid);
    c_full: cover property (@(posedge core_clk) disable iff (!rstn) queue_full[0]);
    c_overflow: cover property (@(posedge core_clk) disable iff (!rstn) overflow[3]);
endmodule

/* File: tb/test_receive_event_queue_encoder.sv */
// Self-checking bench for the receive event queue encoder.
// Assumes rxq_pkg, entry_if, rxq_store and the encoder are compiled first.
`timescale 1ns/1ps
module test_receive_event_queue_encoder
    import rxq_pkg::*;
;
    logic core_clk, rstn, ev_valid, ev_fifo_mode, ev_crc_bad, ev_length_bad, ev_cpi_nonzero;
    logic ev_keep_bad_frames, ev_crc10_check, deq_en, ev_ready, deq_valid, spread;
    source_type ev_source;
    pool_kind_type ev_pool_kind;
    dma_kind_type ev_dma_kind;
    logic [2:0] ev_queue, deq_queue, tgt;
    logic [1:0] ev_counter_sel;
    logic [5:0] ev_raw_code;
    logic [INFO_WIDTH-1:0] ev_buffer_ptr, ev_descriptor_ptr;
    logic [ENTRY_WIDTH-1:0] deq_entry;
    logic [QUEUE_COUNT-1:0] queue_nonempty, queue_full, overflow;
    logic [CLASS_WIDTH-1:0] last_class;
    logic [31:0] seed;
    logic [31:0] exp_q[$];
    logic [31:0] model[8][$];
    int mismatches, tests_run;

    receive_event_queue_encoder u_receive_event_queue_encoder (.core_clk, .rstn, .ev_valid,
        .ev_source, .ev_queue, .ev_buffer_ptr, .ev_descriptor_ptr, .ev_fifo_mode, .ev_crc_bad,
        .ev_length_bad, .ev_cpi_nonzero, .ev_keep_bad_frames, .ev_crc10_check, .ev_pool_kind,
        .ev_counter_sel, .ev_dma_kind, .ev_raw_code, .deq_queue, .deq_en, .ev_ready,
        .deq_entry, .deq_valid, .queue_nonempty, .queue_full, .last_class, .overflow);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [6:0] cls_of(input logic [5:0] c);
        cls_of[0] = c inside {[6'h02:6'h07], [6'h0A:6'h0D], [6'h0F:6'h13], 6'h16,
                              [6'h38:6'h3A], 6'h3C};
        cls_of[1] = c inside {[6'h18:6'h1B], 6'h3D};
        cls_of[2] = c inside {[6'h1E:6'h23]};
        cls_of[3] = c inside {6'h24, 6'h26, 6'h28, 6'h29};
        cls_of[4] = c inside {6'h25, 6'h27, 6'h29, 6'h3B};
        cls_of[5] = c inside {[6'h2C:6'h2F]};
        cls_of[6] = c == 6'h3E;
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task stop_test();
        $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Called just after a rising edge; qual is {fifo, crc, len, cpi, keep, crc10}.
    task send(input source_type s, input logic [5:0] code, input logic [5:0] qual,
              input logic [2:0] sub, input bit use_buf);
        logic [31:0] want;
        bit room;
        ev_source = s;
        ev_raw_code = code;
        {ev_fifo_mode, ev_crc_bad, ev_length_bad, ev_cpi_nonzero, ev_keep_bad_frames,
            ev_crc10_check} = qual;
        ev_counter_sel = sub[1:0];
        ev_pool_kind = pool_kind_type'(sub[1:0]);
        ev_dma_kind = dma_kind_type'(sub);
        ev_queue = tgt;
        want = rnd();
        ev_buffer_ptr = want[25:0];
        want = rnd();
        ev_descriptor_ptr = want[25:0];
        want = {use_buf ? ev_buffer_ptr : ev_descriptor_ptr, code};
        room = model[tgt].size() < QUEUE_DEPTH;
        if (room) model[tgt].push_back(want);
        ev_valid = 1'b1;
        @(posedge core_clk);
        #1;
        if (room) check({25'h0, last_class}, {25'h0, cls_of(code)});
        if (spread) tgt = tgt + 3'h1;
    endtask

    // A second cycle of deq_en right after a taken pop must be ignored.
    task pop(input logic [2:0] q, input int hold);
        deq_queue = q;
        deq_en = 1'b1;
        if (model[q].size() > 0) exp_q.push_back(model[q].pop_front());
        repeat (hold) begin
            @(posedge core_clk);
            #1;
        end
        deq_en = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task drain();
        for (int q = 0; q < 8; q++) begin
            while (model[q].size() > 0) pop(q[2:0], 1);
        end
        check(exp_q.size(), 0);
        check({24'h0, queue_nonempty}, 32'h0);
    endtask

    always @(negedge core_clk) begin
        if (deq_valid === 1'b1) begin
            if (exp_q.size() == 0) check({31'h0, deq_valid}, 32'h0);
            else check(deq_entry, exp_q.pop_front());
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #(25 * 2000);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        {rstn, ev_valid, deq_en, spread, ev_fifo_mode, ev_crc_bad, ev_length_bad} = 7'h00;
        {ev_cpi_nonzero, ev_keep_bad_frames, ev_crc10_check} = 3'h0;
        {ev_queue, deq_queue, tgt, ev_counter_sel, ev_raw_code} = 17'h0;
        {ev_buffer_ptr, ev_descriptor_ptr} = 52'h0;
        ev_source = SRC_PKT_DONE;
        ev_pool_kind = POOL_AAL0;
        ev_dma_kind = DMA_TX_OK;
        seed = 32'h13D3E475;
        repeat (12) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        check({ev_ready, deq_valid, queue_nonempty, overflow}, {1'b1, 1'b0, 16'h0});
        spread = 1'b1;
        send(SRC_PKT_DONE, 6'h00, 6'h00, 3'h0, 1);
        send(SRC_PKT_DONE, 6'h0E, 6'h20, 3'h0, 1);
        send(SRC_PKT_HEADER, 6'h01, 6'h00, 3'h0, 1);
        send(SRC_PKT_DONE, 6'h02, 6'h18, 3'h0, 0);
        send(SRC_PKT_DONE, 6'h0F, 6'h12, 3'h0, 1);
        send(SRC_PKT_DONE, 6'h03, 6'h08, 3'h0, 0);
        send(SRC_PKT_TOO_LONG, 6'h04, 6'h02, 3'h0, 1);
        send(SRC_PKT_TIMEOUT, 6'h05, 6'h00, 3'h0, 0);
        send(SRC_PKT_ABORT, 6'h06, 6'h02, 3'h0, 1);
        send(SRC_PKT_DONE, 6'h07, 6'h1E, 3'h0, 1);
        send(SRC_CELL, 6'h08, 6'h00, 3'h0, 1);
        send(SRC_NUD_CELL, 6'h09, 6'h10, 3'h0, 1);
        send(SRC_NUD_CELL, 6'h09, 6'h01, 3'h0, 1);
        send(SRC_NUD_CELL, 6'h0A, 6'h11, 3'h0, 0);
        send(SRC_BAD_HEC, 6'h0B, 6'h00, 3'h0, 1);
        send(SRC_OUT_RANGE, 6'h0C, 6'h00, 3'h0, 1);
        send(SRC_INDEX_ZERO, 6'h0D, 6'h00, 3'h0, 1);
        for (int i = 0; i < 3; i++) send(SRC_POOL_DROP, 6'h10 + i[5:0], 6'h00, i[2:0], 0);
        send(SRC_FIFO_DROP, 6'h13, 6'h20, 3'h0, 0);
        send(SRC_FIFO_THRESH, 6'h14, 6'h20, 3'h0, 0);
        send(SRC_FIFO_FULL, 6'h15, 6'h20, 3'h0, 0);
        send(SRC_FIFO_TIMEOUT, 6'h16, 6'h20, 3'h0, 0);
        for (int i = 0; i < 4; i++) send(SRC_COUNTER, 6'h18 + i[5:0], 6'h00, i[2:0], 0);
        send(SRC_ENTITY_CNT, 6'h3D, 6'h00, 3'h0, 1);
        for (int i = 0; i < 6; i++) send(SRC_DMA, 6'h24 + i[5:0], 6'h00, i[2:0], 0);
        for (int i = 0; i < 8; i++) send(SRC_RAW, 6'h30 + i[5:0], 6'h00, 3'h0, 1);
        ev_valid = 1'b0;
        @(posedge core_clk);
        #1;
        check({24'h0, queue_nonempty}, 32'hFF);
        drain();
        $display("Test event encoding done");
        spread = 1'b0;
        tgt = 3'h5;
        repeat (17) send(SRC_RAW, 6'h31, 6'h00, 3'h0, 1);
        tgt = 3'h2;
        send(SRC_RAW, 6'h37, 6'h00, 3'h0, 1);
        ev_valid = 1'b0;
        @(posedge core_clk);
        #1;
        check({queue_full, overflow, ev_ready}, {8'h20, 8'h20, 1'b0});
        pop(3'h5, 2);
        drain();
        check({overflow, ev_ready}, {8'h20, 1'b1});
        pop(3'h3, 1);
        tgt = 3'h0;
        send(SRC_RAW, 6'h33, 6'h00, 3'h0, 1);
        ev_valid = 1'b0;
        pop(3'h0, 1);
        repeat (3) @(posedge core_clk);
        $display("Test full queue done");
        stop_test();
    end
endmodule
